// ---- smart_card_sequencer_map.svh ----
// Contract
// - divide select 00/01/10/11 gives 1/8, 1/4, 1, 1/2
// - halt stops card clock at chosen level
// - refuse activation 10ms after reset or supply recovery
// - activation on falling power request edge only
// - activate only with card, no thermal/supply fault
// - end of t1: bad card supply, flag and unpower
// - reset low at request: reception at t2 end
// - card clock at t3 end, after reception
// - card reset follows host after 42000 clocks
// - reset high at request: reception on its fall
// - deactivate on request release or any fault
// - six fault sources all force deactivation
// - regulator below card supply is one fault
// - deactivate: reset, clock, lines, power in order
// - idle presence output shows card presence
// - idle faults ignored, no deactivation
// - session fault: flag low, deactivate at once
// - card lines low until reception, then high
// - host lines rest high after reset
// - first falling side becomes input, other driven
// - input rising edge releases both lines
// - halt input is active high
`ifndef SMART_CARD_SEQUENCER_MAP_SVH
`define SMART_CARD_SEQUENCER_MAP_SVH

`define CTRL_OFFSET      32'h0000_0000
`define STATUS_OFFSET    32'h0000_0004
`define CTRL_W           4
`define CTRL_RESET       4'h0
`define CTRL_SEL_B_BIT   0
`define CTRL_SEL_A_BIT   1
`define CTRL_HALT_BIT    2
`define CTRL_LEVEL_BIT   3
`define ST_SEQ_LSB       0
`define ST_SEQ_MSB       3
`define ST_OFF_BIT       4
`define ST_POWER_BIT     5
`define ST_RX_BIT        6
`define ST_CLKRUN_BIT    7
`define ST_PORDONE_BIT   8
`define ST_RESET_BIT     9

`define DIV_8            2'h0
`define DIV_4            2'h1
`define DIV_1            2'h2
`define DIV_2            2'h3
`define TERM_DIV_8       2'h3
`define TERM_DIV_4       2'h1
`define TERM_DIV_2       2'h0

`define CLK_PERIOD_NS    5
`define POR_DELAY_MS     10
`define POR_DELAY_CYCLES ((`POR_DELAY_MS * 1000000) / `CLK_PERIOD_NS)
`define RST_HOLD_CLKS    42000
`define INTERVAL_CYCLES  200
`define TIMER_W          24
`define CLKCNT_W         16
`define LANES            3

`endif

// ---- smart_card_sequencer_pkg.sv ----
`include "smart_card_sequencer_map.svh"
package smart_card_sequencer_pkg;

    typedef enum logic [3:0] {
        SEQ_IDLE, SEQ_ACT1, SEQ_ACT2, SEQ_ACT3, SEQ_ACT4, SEQ_ACTIVE,
        SEQ_DEACT1, SEQ_DEACT2, SEQ_DEACT3, SEQ_DEACT4, SEQ_HOLD
    } seq_t;

    typedef enum logic [1:0] {
        LANE_NEUTRAL, LANE_CARD_IN, LANE_HOST_IN
    } lane_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } ahb_req_t;

    typedef struct packed {
        seq_t                     seq;
        logic [`TIMER_W-1:0]      timer;
        logic [`TIMER_W-1:0]      por_cnt;
        logic                     por_done;
        logic                     req_prev;
        logic                     rst_prev;
        logic                     rst_low_at_req;
        logic                     rx_en;
        logic                     clk_run;
        logic                     power;
        logic                     card_reset;
        logic                     off_n;
        logic                     osc_prev;
        logic [1:0]               div_cnt;
        logic                     div_clk;
        logic                     card_clock;
        logic [`CLKCNT_W-1:0]     clk_cnt;
        lane_t [`LANES-1:0]       lane;
        logic [`LANES-1:0]        card_prev;
        logic [`LANES-1:0]        host_prev;
        logic [`LANES-1:0]        card_out;
        logic [`LANES-1:0]        card_oe;
        logic [`LANES-1:0]        host_out;
        logic [`LANES-1:0]        host_oe;
        logic [`CTRL_W-1:0]       ctrl;
        logic                     wr_pend;
        logic [31:0]              hrdata;
        logic                     hreadyout;
        logic                     hresp;
    } core_state_t;

endpackage : smart_card_sequencer_pkg

// ---- smart_card_sequencer.sv ----
`timescale 1ns/1ps
`include "smart_card_sequencer_map.svh"
module smart_card_sequencer #(
    parameter int unsigned POR_DELAY_CYCLES = `POR_DELAY_CYCLES,
    parameter int unsigned RST_HOLD_CLKS    = `RST_HOLD_CLKS,
    parameter int unsigned ACT_T1           = `INTERVAL_CYCLES,
    parameter int unsigned ACT_T2           = `INTERVAL_CYCLES,
    parameter int unsigned ACT_T3           = `INTERVAL_CYCLES,
    parameter int unsigned ACT_T4           = `INTERVAL_CYCLES,
    parameter int unsigned DEACT_T1         = `INTERVAL_CYCLES,
    parameter int unsigned DEACT_T2         = `INTERVAL_CYCLES,
    parameter int unsigned DEACT_T3         = `INTERVAL_CYCLES,
    parameter int unsigned DEACT_T4         = `INTERVAL_CYCLES
) (
    // clock and reset
    input  wire logic                                ref_clk_in,
    input  wire logic                                rst_n_in,
    // register bus
    input  wire smart_card_sequencer_pkg::ahb_req_t  ahb_in,
    output logic [31:0]                              hrdata_out,
    output logic                                     hreadyout_out,
    output logic                                     hresp_out,
    // host control
    input  wire logic                                card_power_request_n_in,
    input  wire logic                                host_reset_in,
    input  wire logic                                osc_input_in,
    // supervisors and detection
    input  wire logic                                card_detect_in,
    input  wire logic                                overcurrent_in,
    input  wire logic                                overtemp_in,
    input  wire logic                                vdd_fault_in,
    input  wire logic                                regulator_below_card_in,
    input  wire logic                                card_supply_valid_in,
    // card control
    output logic                                     card_power_en_out,
    output logic                                     card_reset_out,
    output logic                                     card_clock_out,
    output logic                                     presence_fault_n_out,
    // line pairs: 0 data, 1 aux 1, 2 aux 2
    input  wire logic [`LANES-1:0]                   card_line_in,
    output logic [`LANES-1:0]                        card_line_out,
    output logic [`LANES-1:0]                        card_line_oe_out,
    input  wire logic [`LANES-1:0]                   host_line_in,
    output logic [`LANES-1:0]                        host_line_out,
    output logic [`LANES-1:0]                        host_line_oe_out
);
    import smart_card_sequencer_pkg::*;

    localparam core_state_t RESET_STATE = '{
        seq:      SEQ_IDLE,
        req_prev: 1'b1,
        card_oe:  {`LANES{1'b1}},
        host_out: {`LANES{1'b1}},
        ctrl:     `CTRL_RESET,
        hreadyout: 1'b1,
        default:  '0
    };

    core_state_t s;
    core_state_t n;

    logic in_session;
    logic fault;
    logic abort;
    logic start;
    logic timer_done;

    function automatic logic [`TIMER_W-1:0] load(input int unsigned cycles);
        return `TIMER_W'(cycles - 1);
    endfunction : load

    assign in_session = (s.seq == SEQ_ACT1) || (s.seq == SEQ_ACT2) || (s.seq == SEQ_ACT3)
                        || (s.seq == SEQ_ACT4) || (s.seq == SEQ_ACTIVE);
    // card supply is only judged once t1 has given it time to rise
    assign fault = overcurrent_in | overtemp_in | vdd_fault_in | regulator_below_card_in
                   | (in_session && s.seq != SEQ_ACT1 && !card_supply_valid_in)
                   | !card_detect_in;
    assign abort = in_session && (card_power_request_n_in || fault);
    assign start = (s.seq == SEQ_IDLE) && s.req_prev && !card_power_request_n_in
                   && s.por_done
                   && card_detect_in && !overtemp_in && !vdd_fault_in;
    assign timer_done = (s.timer == '0);

    always_comb begin
        logic [1:0]  sel;
        logic [1:0]  term;
        logic        osc_rise;
        logic [31:0] status;
        logic        accept;
        n        = s;
        sel      = s.ctrl[`CTRL_SEL_A_BIT:`CTRL_SEL_B_BIT];
        term     = `TERM_DIV_8;
        osc_rise = osc_input_in & ~s.osc_prev;
        status   = '0;
        accept   = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;

        n.req_prev  = card_power_request_n_in;
        n.rst_prev  = host_reset_in;
        n.osc_prev  = osc_input_in;
        n.card_prev = card_line_in;
        n.host_prev = host_line_in;

        // supply recovery restarts the settle delay
        if (vdd_fault_in) begin
            n.por_cnt  = '0;
            n.por_done = 1'b0;
        end else if (!s.por_done) begin
            if (s.por_cnt == `TIMER_W'(POR_DELAY_CYCLES - 1))
                n.por_done = 1'b1;
            else
                n.por_cnt = s.por_cnt + 1'b1;
        end

        if (!timer_done)
            n.timer = s.timer - 1'b1;

        if (abort) begin
            n.seq   = SEQ_DEACT1;
            n.timer = load(DEACT_T1);
            if (fault)
                n.off_n = 1'b0;
        end else begin
            unique case (s.seq)
                SEQ_IDLE: begin
                    n.off_n = card_detect_in;
                    if (start) begin
                        n.seq            = SEQ_ACT1;
                        n.power          = 1'b1;
                        n.timer          = load(ACT_T1);
                        n.rst_low_at_req = !host_reset_in;
                    end
                end
                SEQ_ACT1: if (timer_done) begin
                    if (!card_supply_valid_in) begin
                        n.off_n = 1'b0;
                        n.power = 1'b0;
                        n.seq   = SEQ_HOLD;
                    end else begin
                        n.seq   = SEQ_ACT2;
                        n.timer = load(ACT_T2);
                    end
                end
                SEQ_ACT2: begin
                    if (!s.rst_low_at_req && s.rst_prev && !host_reset_in)
                        n.rx_en = 1'b1;
                    // a reset that never falls still opens reception at t2 end
                    if (timer_done) begin
                        n.rx_en = 1'b1;
                        n.seq   = SEQ_ACT3;
                        n.timer = load(ACT_T3);
                    end
                end
                SEQ_ACT3: if (timer_done) begin
                    n.clk_run = 1'b1;
                    n.clk_cnt = '0;
                    n.seq     = SEQ_ACT4;
                    n.timer   = load(ACT_T4);
                end
                SEQ_ACT4: if (timer_done)
                    n.seq = SEQ_ACTIVE;
                SEQ_ACTIVE:
                    n.card_reset = host_reset_in && (s.clk_cnt >= `CLKCNT_W'(RST_HOLD_CLKS));
                SEQ_DEACT1: begin
                    if (fault && !card_power_request_n_in)
                        n.off_n = 1'b0;
                    if (timer_done) begin
                        n.card_reset = 1'b0;
                        n.seq        = SEQ_DEACT2;
                        n.timer      = load(DEACT_T2);
                    end
                end
                SEQ_DEACT2: begin
                    if (fault && !card_power_request_n_in)
                        n.off_n = 1'b0;
                    if (timer_done) begin
                        n.clk_run = 1'b0;
                        n.seq     = SEQ_DEACT3;
                        n.timer   = load(DEACT_T3);
                    end
                end
                SEQ_DEACT3: begin
                    if (fault && !card_power_request_n_in)
                        n.off_n = 1'b0;
                    if (timer_done) begin
                        n.rx_en = 1'b0;
                        n.seq   = SEQ_DEACT4;
                        n.timer = load(DEACT_T4);
                    end
                end
                SEQ_DEACT4: begin
                    if (fault && !card_power_request_n_in)
                        n.off_n = 1'b0;
                    if (timer_done) begin
                        n.power = 1'b0;
                        n.seq   = card_power_request_n_in ? SEQ_IDLE : SEQ_HOLD;
                    end
                end
                // fault stays reported until the host drops its request
                SEQ_HOLD: if (card_power_request_n_in)
                    n.seq = SEQ_IDLE;
                default: n.seq = SEQ_IDLE;
            endcase
        end

        // card clock divider, counts rising edges of the oscillator
        unique case (sel)
            `DIV_8: term = `TERM_DIV_8;
            `DIV_4: term = `TERM_DIV_4;
            `DIV_2: term = `TERM_DIV_2;
            `DIV_1: term = `TERM_DIV_2;
        endcase
        if (osc_rise) begin
            if (s.div_cnt >= term) begin
                n.div_cnt = '0;
                n.div_clk = ~s.div_clk;
            end else begin
                n.div_cnt = s.div_cnt + 1'b1;
            end
        end
        // bypass needs the oscillator below half the system clock
        if (!s.clk_run)
            n.card_clock = 1'b0;
        else if (s.ctrl[`CTRL_HALT_BIT])
            n.card_clock = s.ctrl[`CTRL_LEVEL_BIT];
        else if (sel == `DIV_1)
            n.card_clock = osc_input_in;
        else
            n.card_clock = s.div_clk;
        if (n.card_clock && !s.card_clock && !s.ctrl[`CTRL_HALT_BIT]
            && s.clk_cnt != '1)
            n.clk_cnt = s.clk_cnt + 1'b1;

        // line pairs
        for (int i = 0; i < `LANES; i++) begin
            if (!s.rx_en) begin
                n.lane[i]     = LANE_NEUTRAL;
                n.card_out[i] = 1'b0;
                n.card_oe[i]  = 1'b1;
                n.host_out[i] = 1'b1;
                n.host_oe[i]  = 1'b0;
            end else begin
                unique case (s.lane[i])
                    LANE_NEUTRAL: begin
                        n.card_out[i] = 1'b1;
                        n.card_oe[i]  = 1'b0;
                        n.host_out[i] = 1'b1;
                        n.host_oe[i]  = 1'b0;
                        if (s.card_prev[i] && !card_line_in[i]) begin
                            n.lane[i]     = LANE_CARD_IN;
                            n.host_out[i] = 1'b0;
                            n.host_oe[i]  = 1'b1;
                        end else if (s.host_prev[i] && !host_line_in[i]) begin
                            n.lane[i]    = LANE_HOST_IN;
                            n.card_out[i] = 1'b0;
                            n.card_oe[i]  = 1'b1;
                        end
                    end
                    LANE_CARD_IN: begin
                        n.host_out[i] = card_line_in[i];
                        if (!s.card_prev[i] && card_line_in[i]) begin
                            n.lane[i]     = LANE_NEUTRAL;
                            n.host_out[i] = 1'b1;
                            n.host_oe[i]  = 1'b0;
                        end
                    end
                    LANE_HOST_IN: begin
                        n.card_out[i] = host_line_in[i];
                        if (!s.host_prev[i] && host_line_in[i]) begin
                            n.lane[i]     = LANE_NEUTRAL;
                            n.card_out[i] = 1'b1;
                            n.card_oe[i]  = 1'b0;
                        end
                    end
                    default: n.lane[i] = LANE_NEUTRAL;
                endcase
            end
        end

        // bus slave, zero wait states; write lands in the data phase
        n.wr_pend = accept && ahb_in.hwrite && (ahb_in.haddr == `CTRL_OFFSET);
        if (s.wr_pend)
            n.ctrl = ahb_in.hwdata[`CTRL_W-1:0];
        status[`ST_SEQ_MSB:`ST_SEQ_LSB] = n.seq;
        status[`ST_OFF_BIT]     = n.off_n;
        status[`ST_POWER_BIT]   = n.power;
        status[`ST_RX_BIT]      = n.rx_en;
        status[`ST_CLKRUN_BIT]  = n.clk_run;
        status[`ST_PORDONE_BIT] = n.por_done;
        status[`ST_RESET_BIT]   = n.card_reset;
        n.hrdata = '0;
        if (accept && !ahb_in.hwrite) begin
            if (ahb_in.haddr == `CTRL_OFFSET)
                n.hrdata = {{(32 - `CTRL_W){1'b0}}, n.ctrl};
            else if (ahb_in.haddr == `STATUS_OFFSET)
                n.hrdata = status;
        end
        n.hreadyout = 1'b1;
        n.hresp     = 1'b0;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            s <= RESET_STATE;
        else
            s <= n;
    end

    assign hrdata_out           = s.hrdata;
    assign hreadyout_out        = s.hreadyout;
    assign hresp_out            = s.hresp;
    assign card_power_en_out    = s.power;
    assign card_reset_out       = s.card_reset;
    assign card_clock_out       = s.card_clock;
    assign presence_fault_n_out = s.off_n;
    assign card_line_out        = s.card_out;
    assign card_line_oe_out     = s.card_oe;
    assign host_line_out        = s.host_out;
    assign host_line_oe_out     = s.host_oe;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence seq_start;
        s.seq == SEQ_IDLE ##1 s.seq == SEQ_ACT1;
    endsequence
    sequence seq_deact_done;
        s.seq == SEQ_DEACT4 && timer_done && !abort;
    endsequence

    a_start_after_delay: assert property (seq_start |-> $past(s.por_done))
        else $error("activation inside settle delay");
    a_start_on_edge: assert property (seq_start |-> $past(s.req_prev) && !$past(card_power_request_n_in))
        else $error("activation without falling request edge");
    a_start_clean: assert property (seq_start |-> $past(card_detect_in) && !$past(overtemp_in)
                                    && !$past(vdd_fault_in))
        else $error("activation with card absent or fault");
    a_supply_check: assert property (s.seq == SEQ_ACT1 && timer_done && !abort && !card_supply_valid_in
                                     |=> !presence_fault_n_out && !card_power_en_out)
        else $error("bad card supply not reported");
    a_clock_after_rx: assert property (s.clk_run |-> s.rx_en && card_power_en_out)
        else $error("card clock before reception");
    a_reset_hold: assert property ($rose(card_reset_out) |-> s.clk_cnt >= RST_HOLD_CLKS)
        else $error("card reset released too early");
    a_rx_on_fall: assert property (s.seq == SEQ_ACT2 && !s.rst_low_at_req && s.rst_prev
                                   && !host_reset_in && !abort |=> s.rx_en)
        else $error("reception not opened on reset fall");
    a_deact_order: assert property (seq_deact_done |=> !card_power_en_out && !card_reset_out
                                    && !card_clock_out && !s.rx_en)
        else $error("deactivation left outputs active");
    a_idle_presence: assert property (s.seq == SEQ_IDLE && !start
                                      |=> presence_fault_n_out == $past(card_detect_in))
        else $error("idle presence output wrong");
    a_fault_reaction: assert property (in_session && fault
                                       |=> !presence_fault_n_out && s.seq == SEQ_DEACT1)
        else $error("session fault not handled");
    a_halt_level: assert property (s.seq == SEQ_ACTIVE && s.clk_run && s.ctrl[`CTRL_HALT_BIT]
                                   |=> card_clock_out == $past(s.ctrl[`CTRL_LEVEL_BIT]))
        else $error("halted card clock at wrong level");

endmodule : smart_card_sequencer

// ---- card_model.sv ----
`timescale 1ns/1ps
module card_model (
    // device side of the card lines
    input  wire logic [2:0] out_in,
    input  wire logic [2:0] oe_in,
    // card drives low where its bit is 0
    input  wire logic [2:0] pull_n_in,
    output logic      [2:0] line_out
);
    // released lines float to the card pull-up level
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            line_out[i] = oe_in[i] ? (out_in[i] & pull_n_in[i]) : pull_n_in[i];
        end
    end
endmodule : card_model

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
    import smart_card_sequencer_pkg::*;
    logic clk = 0, rst_n = 0, osc = 0, req_n = 1, hrst = 0, det = 0, oc = 0, ot = 0;
    logic vdd = 0, rbc = 0, sv = 1;
    logic [2:0] cpull = 3'h7, hpull = 3'h7, cin, cout, coe, hout, hoe;
    logic [31:0] hrd, q;
    logic hrdy, hresp, pwr, crst, cclk, card_detect_n;
    ahb_req_t req = '0;
    int err_total = 0, check_count = 0, cyc = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) osc <= cyc[1];
    always @* req.hready = hrdy;
    // interval lengths keep their defaults of 200 cycles
    smart_card_sequencer #(.POR_DELAY_CYCLES(50), .RST_HOLD_CLKS(20)) i_dut (
        .ref_clk_in(clk), .rst_n_in(rst_n), .ahb_in(req), .hrdata_out(hrd), .hreadyout_out(hrdy),
        .hresp_out(hresp), .card_power_request_n_in(req_n), .host_reset_in(hrst), .osc_input_in(osc),
        .card_detect_in(det), .overcurrent_in(oc), .overtemp_in(ot), .vdd_fault_in(vdd),
        .regulator_below_card_in(rbc), .card_supply_valid_in(sv), .card_power_en_out(pwr),
        .card_reset_out(crst), .card_clock_out(cclk), .presence_fault_n_out(card_detect_n),
        .card_line_in(cin), .card_line_out(cout), .card_line_oe_out(coe),
        .host_line_in(hoe & hout | ~hoe & hpull), .host_line_out(hout), .host_line_oe_out(hoe));
    card_model i_card (.out_in(cout), .oe_in(coe), .pull_n_in(cpull), .line_out(cin));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        req.hsel <= 1; req.haddr <= a; req.htrans <= 2'h2; req.hwrite <= wr; req.hsize <= 3'h2;
        do @(posedge clk); while (hrdy !== 1'b1);
        req.hsel <= 0; req.htrans <= 2'h0; req.hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        q = hrd;
    endtask : bus
    task automatic t_idle;
        chk({card_detect_n, coe, cout, hoe}, {1'b0, 3'h7, 3'h0, 3'h0});
        chk({hrdy, hresp, hout}, {1'b1, 1'b0, 3'h7});
        det <= 1; ot <= 1; req_n <= 0;
        w(4);
        chk({card_detect_n, pwr}, 2'h2);
        ot <= 0; req_n <= 1;
        bus(1, 32'h0, 32'h2);
        bus(0, 32'h0, 32'h0);
        chk(q, 32'h2);
        bus(0, 32'h40, 32'h0);
        chk(q, 32'h0);
        $display("done idle");
    endtask : t_idle
    task automatic t_act;
        w(60);
        req_n <= 0;
        w(3);
        chk({pwr, coe, cout, cclk}, {1'b1, 3'h7, 3'h0, 1'b0});
        hrst <= 1;
        w(410);
        chk(cin, 3'h7);
        w(300);
        chk(crst, 1'b0);
        w(100);
        chk(crst, 1'b1);
        $display("done act");
    endtask : t_act
    task automatic t_lines;
        cpull <= 3'h6;
        w(4);
        chk({hoe[0], hout[0]}, 2'h2);
        cpull <= 3'h7;
        w(4);
        chk(hoe[0], 1'b0);
        $display("done lines");
    endtask : t_lines
    task automatic t_fault;
        oc <= 1;
        w(3);
        chk(card_detect_n, 1'b0);
        w(810);
        chk({pwr, crst, cclk, cout}, 6'h0);
        oc <= 0; req_n <= 1;
        $display("done fault");
    endtask : t_fault
    task automatic t_supply;
        sv <= 0;
        w(3);
        req_n <= 0;
        w(205);
        chk({card_detect_n, pwr}, 2'h0);
        req_n <= 1; sv <= 1;
        w(3);
        vdd <= 1;
        w(2);
        vdd <= 0; req_n <= 0;
        w(5);
        chk(pwr, 1'b0);
        req_n <= 1;
        w(60);
        req_n <= 0;
        w(5);
        chk({card_detect_n, pwr}, 2'h3);
        rbc <= 1;
        w(3);
        chk(card_detect_n, 1'b0);
        rbc <= 0; req_n <= 1;
        $display("done supply");
    endtask : t_supply
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            final_report;
        end
    end
    initial begin
        w(2);
        rst_n <= 1;
        t_idle;
        t_act;
        t_lines;
        t_fault;
        t_supply;
        final_report;
    end
endmodule : tb
